// File: src/tdl_pkg.sv
// Package: register map, mode encodings and bus structs for the transfer controller
package tdl_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_SRC = 8'h04;
    localparam logic [7:0] OFF_DST = 8'h08;
    localparam logic [7:0] OFF_CNT = 8'h0c;
    localparam logic [7:0] OFF_BLK = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    // Mode word field positions
    localparam int MODE_SM_HI = 7;
    localparam int MODE_SM_LO = 6;
    localparam int MODE_DM_HI = 5;
    localparam int MODE_DM_LO = 4;
    localparam int MODE_MD_HI = 3;
    localparam int MODE_MD_LO = 2;
    localparam int MODE_SIDE = 1;
    localparam int MODE_SIZE = 0;
    // Control and status bits
    localparam int CTRL_START = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_ERR = 2;
    // Reset values of own registers
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [23:0] ADDR_RST = 24'h000000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    // Encodings
    localparam logic [1:0] MD_NORMAL = 2'h0;
    localparam logic [1:0] MD_REPEAT = 2'h1;
    localparam logic [1:0] MD_BLOCK = 2'h2;
    localparam logic [1:0] STEP_FIXED = 2'h0;
    localparam logic [1:0] STEP_INC = 2'h2;
    localparam logic [1:0] STEP_DEC = 2'h3;
    localparam int FIFO_DEPTH = 32;
    localparam int DATA_W = 16;

    typedef enum logic [2:0] {TDL_IDLE, TDL_RD, TDL_RWAIT, TDL_WR, TDL_WWAIT, TDL_NEXT} tdl_state_t;

    // Internal bus request toward memory and peripherals
    typedef struct packed {
        logic req;
        logic we;
        logic word;
        logic [23:0] addr;
        logic [15:0] wdata;
    } tdl_ibus_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] rdata;
    } tdl_ibus_rsp_t;
endpackage

// File: src/tdl_fifo.sv
// Parameterised valid/ready FIFO for moved data
`timescale 1ns/10ps
module tdl_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    // Flush
    input wire logic i_clear
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } tdl_fifo_st_t;
    logic [WIDTH-1:0] mem [DEPTH];
    tdl_fifo_st_t s_q;
    tdl_fifo_st_t s_d;
    logic push;
    logic pop;

    assign o_in_ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (s_q.cnt != '0);
    assign o_out_data = mem[s_q.rp];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        s_d = s_q;
        if (i_clear) begin
            s_d = '0;
        end else begin
            if (push) begin
                s_d.wp = s_q.wp + 1'b1;
            end
            if (pop) begin
                s_d.rp = s_q.rp + 1'b1;
            end
            s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Storage has no reset; only pointers and count matter
    always_ff @(posedge i_ref_clk) begin
        if (push && !i_clear) begin
            mem[s_q.wp] <= i_in_data;
        end
    end
endmodule

// File: src/tdl_core.sv
// Transfer descriptor logic: APB descriptor registers and the transfer sequencer
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module tdl_core (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Internal bus master
    output tdl_pkg::tdl_ibus_req_t o_ibus,
    input wire tdl_pkg::tdl_ibus_rsp_t i_ibus,
    // Activity
    output logic o_busy
);
    typedef struct packed {
        tdl_pkg::tdl_state_t st;
        logic [7:0] mode;
        logic [23:0] src;
        logic [23:0] dst;
        logic [15:0] cnt;
        logic [15:0] blk;
        logic [7:0] rpt_len;
        logic [23:0] rpt_base;
        logic [7:0] blk_pos;
        logic done;
        logic err;
        logic [31:0] prdata;
        tdl_pkg::tdl_ibus_req_t bus;
    } tdl_core_st_t;

    tdl_core_st_t s_q;
    tdl_core_st_t s_d;
    logic wr_acc;
    logic rd_acc;
    logic f_in_valid;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [15:0] f_out_data;
    logic [15:0] f_in_data;

    // Signed step for one pointer given its step field and size
    function automatic logic [23:0] tdl_step(input logic [23:0] a, input logic [1:0] m, input logic word);
        logic [23:0] d;
        d = word ? 24'h000002 : 24'h000001;
        unique case (m)
            tdl_pkg::STEP_INC: tdl_step = a + d;
            tdl_pkg::STEP_DEC: tdl_step = a - d;
            default: tdl_step = a;
        endcase
    endfunction

    function automatic logic [31:0] tdl_fit(input logic [31:0] v, input int w);
        tdl_fit = v & ((32'h1 << w) - 32'h1);
    endfunction

    logic sz_word;
    logic [1:0] md;
    logic side_src;
    logic [1:0] sm;
    logic [1:0] dm;
    assign sz_word = s_q.mode[tdl_pkg::MODE_SIZE];
    assign side_src = s_q.mode[tdl_pkg::MODE_SIDE];
    assign md = {s_q.mode[tdl_pkg::MODE_MD_HI], s_q.mode[tdl_pkg::MODE_MD_LO]};
    assign sm = {s_q.mode[tdl_pkg::MODE_SM_HI], s_q.mode[tdl_pkg::MODE_SM_LO]};
    assign dm = {s_q.mode[tdl_pkg::MODE_DM_HI], s_q.mode[tdl_pkg::MODE_DM_LO]};

    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign rd_acc = i_psel && !i_penable && !i_pwrite;
    assign o_pready = 1'b1;
    assign o_prdata = s_q.prdata;
    assign o_ibus = s_q.bus;
    assign o_busy = (s_q.st != tdl_pkg::TDL_IDLE);
    assign f_in_data = sz_word ? i_ibus.rdata : {8'h00, i_ibus.rdata[7:0]};

    // Read data goes through the FIFO; write phase drains it
    assign f_in_valid = (s_q.st == tdl_pkg::TDL_RWAIT) && i_ibus.ack;
    assign f_out_ready = (s_q.st == tdl_pkg::TDL_WWAIT) && i_ibus.ack;

    always_comb begin
        logic unmapped;
        logic end_unit;
        unmapped = 1'b1;
        end_unit = 1'b0;
        s_d = s_q;
        o_pslverr = 1'b0;
        unique case (i_paddr)
            tdl_pkg::OFF_MODE, tdl_pkg::OFF_SRC, tdl_pkg::OFF_DST, tdl_pkg::OFF_CNT,
            tdl_pkg::OFF_BLK, tdl_pkg::OFF_CTRL, tdl_pkg::OFF_STAT: unmapped = 1'b0;
            default: unmapped = 1'b1;
        endcase
        if (i_psel && i_penable) begin
            o_pslverr = unmapped;
        end
        // Read data captured in setup so it is steady in access
        if (rd_acc) begin
            unique case (i_paddr)
                tdl_pkg::OFF_MODE: s_d.prdata = {24'h000000, s_q.mode};
                tdl_pkg::OFF_SRC: s_d.prdata = {8'h00, s_q.src};
                tdl_pkg::OFF_DST: s_d.prdata = {8'h00, s_q.dst};
                tdl_pkg::OFF_CNT: s_d.prdata = {16'h0000, s_q.cnt};
                tdl_pkg::OFF_BLK: s_d.prdata = {16'h0000, s_q.blk};
                tdl_pkg::OFF_STAT: s_d.prdata = {29'h0, s_q.err, s_q.done, o_busy};
                default: s_d.prdata = 32'h00000000;
            endcase
        end
        if (wr_acc && s_q.st == tdl_pkg::TDL_IDLE) begin
            unique case (i_paddr)
                tdl_pkg::OFF_MODE: s_d.mode = i_pwdata[7:0];
                tdl_pkg::OFF_SRC: s_d.src = i_pwdata[23:0];
                tdl_pkg::OFF_DST: s_d.dst = i_pwdata[23:0];
                tdl_pkg::OFF_CNT: s_d.cnt = i_pwdata[15:0];
                tdl_pkg::OFF_BLK: s_d.blk = i_pwdata[15:0];
                default: ;
            endcase
        end
        unique case (s_q.st)
            tdl_pkg::TDL_IDLE: begin
                // Start only from idle; writes in flight are ignored
                if (wr_acc && i_paddr == tdl_pkg::OFF_CTRL && i_pwdata[tdl_pkg::CTRL_START]) begin
                    s_d.done = 1'b0;
                    s_d.err = 1'b0;
                    if (md == 2'h3) begin
                        s_d.err = 1'b1;
                        s_d.done = 1'b1;
                    end else begin
                        // repeat and block keep area length and base
                        s_d.rpt_len = s_q.cnt[15:8];
                        s_d.rpt_base = side_src ? s_q.src : s_q.dst;
                        s_d.blk_pos = s_q.cnt[7:0];
                        s_d.st = tdl_pkg::TDL_RD;
                    end
                end
            end
            tdl_pkg::TDL_RD: begin
                if (f_in_ready) begin
                    s_d.bus = '{req: 1'b1, we: 1'b0, word: sz_word, addr: s_q.src, wdata: 16'h0000};
                    s_d.st = tdl_pkg::TDL_RWAIT;
                end
            end
            tdl_pkg::TDL_RWAIT: begin
                if (i_ibus.ack) begin
                    s_d.bus.req = 1'b0;
                    s_d.err = s_q.err | i_ibus.err;
                    s_d.st = tdl_pkg::TDL_WR;
                end
            end
            tdl_pkg::TDL_WR: begin
                if (f_out_valid) begin
                    s_d.bus = '{req: 1'b1, we: 1'b1, word: sz_word, addr: s_q.dst, wdata: f_out_data};
                    s_d.st = tdl_pkg::TDL_WWAIT;
                end
            end
            tdl_pkg::TDL_WWAIT: begin
                if (i_ibus.ack) begin
                    s_d.bus.req = 1'b0;
                    s_d.err = s_q.err | i_ibus.err;
                    s_d.dst = tdl_step(s_q.dst, dm, sz_word);
                    s_d.src = tdl_step(s_q.src, sm, sz_word);
                    s_d.st = tdl_pkg::TDL_NEXT;
                end
            end
            tdl_pkg::TDL_NEXT: begin
                s_d.st = tdl_pkg::TDL_IDLE;
                unique case (md)
                    tdl_pkg::MD_REPEAT: begin
                        // repeat area wraps on the chosen side
                        s_d.cnt[7:0] = s_q.cnt[7:0] - 8'h01;
                        if (s_q.cnt[7:0] == 8'h01) begin
                            s_d.cnt[7:0] = s_q.rpt_len;
                            if (side_src) begin
                                s_d.src = s_q.rpt_base;
                            end else begin
                                s_d.dst = s_q.rpt_base;
                            end
                        end
                        s_d.done = 1'b1;
                    end
                    tdl_pkg::MD_BLOCK: begin
                        s_d.blk_pos = s_q.blk_pos - 8'h01;
                        end_unit = (s_q.blk_pos == 8'h01);
                        if (end_unit) begin
                            s_d.cnt[7:0] = s_q.rpt_len;
                            if (side_src) begin
                                s_d.src = s_q.rpt_base;
                            end else begin
                                s_d.dst = s_q.rpt_base;
                            end
                            s_d.blk = s_q.blk - 16'h0001;
                            s_d.done = 1'b1;
                        end else begin
                            s_d.cnt[7:0] = s_q.blk_pos - 8'h01;
                            s_d.st = tdl_pkg::TDL_RD;
                        end
                    end
                    default: begin
                        s_d.cnt = s_q.cnt - 16'h0001;
                        s_d.done = 1'b1;
                    end
                endcase
            end
            default: s_d.st = tdl_pkg::TDL_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= '{st: tdl_pkg::TDL_IDLE, mode: tdl_pkg::MODE_RST, src: tdl_pkg::ADDR_RST,
                     dst: tdl_pkg::ADDR_RST, cnt: tdl_pkg::CNT_RST, blk: tdl_pkg::CNT_RST,
                     rpt_len: 8'h00, rpt_base: tdl_pkg::ADDR_RST, blk_pos: 8'h00, done: 1'b0,
                     err: 1'b0, prdata: 32'h00000000, bus: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Elastic store between read and write phases
    tdl_fifo #(
        .WIDTH(tdl_pkg::DATA_W),
        .DEPTH(tdl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(f_in_valid),
        .o_in_ready(f_in_ready),
        .i_in_data(f_in_data),
        .o_out_valid(f_out_valid),
        .i_out_ready(f_out_ready),
        .o_out_data(f_out_data),
        .i_clear(1'b0)
    );
endmodule

// File: tb/tdl_core_assertions.sv
// Port-level checks of the transfer controller
`timescale 1ns/10ps
module tdl_core_assertions (
    // Clock, reset and APB
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Internal bus and activity
    input wire tdl_pkg::tdl_ibus_req_t o_ibus,
    input wire tdl_pkg::tdl_ibus_rsp_t i_ibus,
    input wire logic o_busy
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    logic [7:0] mode_q;
    logic [23:0] src_q;
    logic [23:0] dst_q;
    logic [23:0] prev_q;
    logic [15:0] rd_q;
    logic seen_q;
    // Writes while busy are ignored, so shadows skip them
    wire wr_ok = i_psel && i_penable && i_pwrite && !o_busy;
    wire rd_ack = o_ibus.req && !o_ibus.we && i_ibus.ack;
    wire wdata_ok = o_ibus.wdata[7:0] == rd_q[7:0] && (!o_ibus.word || o_ibus.wdata == rd_q);
    function automatic logic [23:0] nxt(logic [23:0] a, logic [1:0] st, logic sz);
        logic [23:0] d;
        d = sz ? 24'h000002 : 24'h000001;
        return st == tdl_pkg::STEP_INC ? a + d : st == tdl_pkg::STEP_DEC ? a - d : a;
    endfunction
    wire [23:0] step_exp = nxt(prev_q, mode_q[7:6], mode_q[0]);
    always_ff @(posedge i_ref_clk) begin
        if (wr_ok && i_paddr == tdl_pkg::OFF_MODE) mode_q <= i_pwdata[7:0];
        if (wr_ok && i_paddr == tdl_pkg::OFF_SRC) src_q <= i_pwdata[23:0];
        if (wr_ok && i_paddr == tdl_pkg::OFF_DST) dst_q <= i_pwdata[23:0];
        if (rd_ack) rd_q <= i_ibus.rdata;
        if (rd_ack) prev_q <= o_ibus.addr;
        seen_q <= rd_ack || (seen_q && !$rose(o_busy));
    end
    sequence s_start;
        $rose(o_busy) && mode_q[3:2] != 2'h3;
    endsequence
    sequence s_first_rd;
        o_ibus.req && !o_ibus.we && o_ibus.addr == src_q;
    endsequence
    AST_SLVERR: assert property (i_psel && i_penable && i_paddr[1:0] == 2'h0 |-> o_pslverr == (i_paddr > 8'h18))
        else $error("slave error mismatch");
    AST_REQ_HOLD: assert property (o_ibus.req && !i_ibus.ack |=> o_ibus.req && $stable(o_ibus))
        else $error("request changed before answer");
    AST_WORD: assert property (o_ibus.req |-> o_ibus.word == mode_q[0])
        else $error("transfer size wrong");
    AST_WDATA: assert property (o_ibus.req && o_ibus.we |-> wdata_ok)
        else $error("written data differs from read data");
    AST_SRC: assert property (s_start |-> ##[0:3] s_first_rd)
        else $error("first read not at source");
    AST_DST: assert property (s_start |-> ##[1:24] (o_ibus.req && o_ibus.we && o_ibus.addr == dst_q))
        else $error("first write not at destination");
    AST_RD_WR: assert property (rd_ack |=> ##[0:4] (o_ibus.req && o_ibus.we))
        else $error("read not followed by write");
    AST_STEP: assert property ($rose(o_ibus.req) && !o_ibus.we && seen_q |-> o_ibus.addr == step_exp)
        else $error("source step wrong");
endmodule
bind tdl_core tdl_core_assertions u_chk (.i_ref_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .o_ibus, .i_ibus, .o_busy);

// File: tb/tdl_mem_model.sv
// Memory and peripheral model on the internal bus
`timescale 1ns/10ps
module tdl_mem_model (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Internal bus
    input wire tdl_pkg::tdl_ibus_req_t i_req,
    output tdl_pkg::tdl_ibus_rsp_t o_rsp,
    // Delay and trace
    input wire logic [1:0] i_lag,
    output logic [23:0] o_rd_addr,
    output logic [23:0] o_wr_addr,
    output logic [15:0] o_wr_data,
    output logic [7:0] o_nrd
);
    logic [1:0] wait_q;
    // Data toggles outside answers so stale reads show
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rsp <= '0;
            wait_q <= 2'h0;
            o_nrd <= 8'h00;
        end else if (i_req.req && !o_rsp.ack && wait_q >= i_lag) begin
            wait_q <= 2'h0;
            o_rsp.ack <= 1'b1;
            if (i_req.we) begin
                o_wr_addr <= i_req.addr;
                o_wr_data <= i_req.wdata;
                o_rsp.rdata <= ~o_rsp.rdata;
            end else begin
                o_rd_addr <= i_req.addr;
                o_nrd <= o_nrd + 8'h01;
                o_rsp.rdata <= i_req.addr[15:0] ^ 16'h5a3c;
            end
        end else begin
            o_rsp.ack <= 1'b0;
            o_rsp.rdata <= ~o_rsp.rdata;
            if (i_req.req && !o_rsp.ack) begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule

// File: tb/tdl_test.sv
// Self-checking bench of the transfer controller
`timescale 1ns/10ps
module tdl_test;
    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic [31:0] rd;
    logic prdy;
    logic perr;
    logic err;
    logic busy;
    logic [1:0] lag = 2'h0;
    tdl_pkg::tdl_ibus_req_t req;
    tdl_pkg::tdl_ibus_rsp_t rsp;
    logic [23:0] ra;
    logic [23:0] wa;
    logic [15:0] wd;
    logic [7:0] nrd;
    logic [31:0] seed = 32'd46;
    int fails = 0;
    int tests_run = 0;
    always #10 i_ref_clk = ~i_ref_clk;
    tdl_core uut (.i_ref_clk, .i_rst_b, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .o_ibus(req), .i_ibus(rsp), .o_busy(busy));
    tdl_mem_model mem (.i_ref_clk, .i_rst_b, .i_req(req), .o_rsp(rsp), .i_lag(lag), .o_rd_addr(ra),
        .o_wr_addr(wa), .o_wr_data(wd), .o_nrd(nrd));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [23:0] nxt(logic [23:0] a, logic [1:0] st, logic sz, int n);
        return st == tdl_pkg::STEP_INC ? a + 24'(n * (sz ? 2 : 1)) : st == tdl_pkg::STEP_DEC ? a - 24'(n * (sz ? 2 : 1)) : a;
    endfunction
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(logic we, logic [7:0] a, logic [31:0] d);
        @(posedge i_ref_clk);
        psel <= 1'b1;
        pwr <= we;
        pa <= a;
        pwd <= d;
        @(posedge i_ref_clk);
        pen <= 1'b1;
        @(posedge i_ref_clk);
        while (prdy !== 1'b1) @(posedge i_ref_clk);
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic stop_test();
        if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Whole run is well under 20000 cycles
    initial begin
        #400000;
        fails++;
        stop_test();
    end
    initial begin
        logic [31:0] r;
        logic [1:0] steps [3];
        logic [1:0] sm;
        logic [1:0] dm;
        logic [1:0] md;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] n0;
        logic [15:0] blk;
        logic [23:0] src;
        logic [23:0] dst;
        logic [15:0] msk;
        logic back;
        int items;
        int n;
        steps = '{tdl_pkg::STEP_FIXED, tdl_pkg::STEP_INC, tdl_pkg::STEP_DEC};
        repeat (3) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        apb(1'b0, tdl_pkg::OFF_SRC, 32'h0);
        check("src_rst", rd, {8'h00, tdl_pkg::ADDR_RST});
        for (int i = 0; i < 24; i++) begin
            sm = steps[rnd() % 3];
            dm = steps[rnd() % 3];
            md = 2'(i % 3);
            r = rnd();
            lo = md == tdl_pkg::MD_BLOCK ? 8'(2 + r[3:2]) : (md == tdl_pkg::MD_REPEAT && r[4]) ? 8'h01 : 8'(2 + r[7:5]);
            hi = r[15:8];
            blk = 16'h0001 + 16'(r[21:16]);
            lag <= r[23:22];
            src = 24'(rnd()) & ~{23'h0, r[0]};
            dst = 24'(rnd()) & ~{23'h0, r[0]};
            n0 = nrd;
            apb(1'b1, tdl_pkg::OFF_MODE, {24'h0, sm, dm, md, r[1], r[0]});
            apb(1'b1, tdl_pkg::OFF_SRC, {8'h0, src});
            apb(1'b1, tdl_pkg::OFF_DST, {8'h0, dst});
            apb(1'b1, tdl_pkg::OFF_CNT, {16'h0, hi, lo});
            apb(1'b1, tdl_pkg::OFF_BLK, {16'h0, blk});
            apb(1'b1, tdl_pkg::OFF_CTRL, 32'h1);
            // Refused write while the block is moving
            if (md == tdl_pkg::MD_BLOCK) apb(1'b1, tdl_pkg::OFF_BLK, 32'hffff);
            repeat (2) @(posedge i_ref_clk);
            while (busy === 1'b1) @(posedge i_ref_clk);
            items = md == tdl_pkg::MD_BLOCK ? int'(lo) : 1;
            back = md == tdl_pkg::MD_BLOCK || (md == tdl_pkg::MD_REPEAT && lo == 8'h01);
            msk = {{8{r[0]}}, 8'hff};
            check("reads", {24'h0, nrd - n0}, 32'(items));
            check("rd_addr", {8'h0, ra}, {8'h0, nxt(src, sm, r[0], items - 1)});
            check("wr_addr", {8'h0, wa}, {8'h0, nxt(dst, dm, r[0], items - 1)});
            check("wr_data", {16'h0, wd & msk}, {16'h0, (ra[15:0] ^ 16'h5a3c) & msk});
            apb(1'b0, tdl_pkg::OFF_SRC, 32'h0);
            check("src", {8'h0, rd[23:0]}, {8'h0, back && r[1] ? src : nxt(src, sm, r[0], items)});
            apb(1'b0, tdl_pkg::OFF_DST, 32'h0);
            check("dst", {8'h0, rd[23:0]}, {8'h0, back && !r[1] ? dst : nxt(dst, dm, r[0], items)});
            apb(1'b0, tdl_pkg::OFF_CNT, 32'h0);
            if (md != tdl_pkg::MD_BLOCK) check("cnt", {16'h0, rd[15:0]}, {16'h0, hi, back ? hi : lo - 8'h01});
            apb(1'b0, tdl_pkg::OFF_BLK, 32'h0);
            check("blk", {16'h0, rd[15:0]}, {16'h0, md == tdl_pkg::MD_BLOCK ? blk - 16'h1 : blk});
        end
        n0 = nrd;
        apb(1'b1, tdl_pkg::OFF_MODE, 32'h0c);
        apb(1'b1, tdl_pkg::OFF_CTRL, 32'h1);
        repeat (4) @(posedge i_ref_clk);
        apb(1'b0, tdl_pkg::OFF_STAT, 32'h0);
        check("stat", rd & 32'h6, 32'h6);
        check("no_reads", {24'h0, nrd}, {24'h0, n0});
        apb(1'b0, 8'h1c, 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        check("pready", {31'h0, prdy}, 32'h1);
        check("unmapped", rd, 32'h0);
        // Long word block: every item of the area passes the buffer
        n0 = nrd;
        n = 0;
        src = 24'h001000;
        apb(1'b1, tdl_pkg::OFF_MODE, 32'h000000a9);
        apb(1'b1, tdl_pkg::OFF_SRC, {8'h0, src});
        apb(1'b1, tdl_pkg::OFF_DST, 32'h00002000);
        apb(1'b1, tdl_pkg::OFF_CNT, 32'h00000020);
        apb(1'b1, tdl_pkg::OFF_BLK, 32'h00000001);
        apb(1'b1, tdl_pkg::OFF_CTRL, 32'h1);
        repeat (2) @(posedge i_ref_clk);
        // Bus values read at the edge are the ones sampled there
        while (busy === 1'b1) begin
            @(posedge i_ref_clk);
            if (req.req === 1'b1 && req.we === 1'b1 && rsp.ack === 1'b1) begin
                dst = nxt(src, tdl_pkg::STEP_INC, 1'b1, n);
                check("fifo_data", {16'h0, req.wdata}, {16'h0, dst[15:0] ^ 16'h5a3c});
                n++;
            end
        end
        check("fifo_fill", {24'h0, nrd - n0}, 32'd32);
        check("fifo_drain", 32'(n), 32'd32);
        stop_test();
    end
endmodule
